// [dtc_pkg.sv]
// Constants shared by the dual timer/counter pair: register addresses,
// bit positions inside each register, mode encodings and reset values.
// Assumes an 8-bit special-function register space with byte registers.
package dtc_pkg;

	localparam logic [7:0] DTC_ADDR_CONTROL   = 8'h88;
	localparam logic [7:0] DTC_ADDR_MODE      = 8'h89;
	localparam logic [7:0] DTC_ADDR_U0_LOW    = 8'h8a;
	localparam logic [7:0] DTC_ADDR_U1_LOW    = 8'h8b;
	localparam logic [7:0] DTC_ADDR_U0_HIGH   = 8'h8c;
	localparam logic [7:0] DTC_ADDR_U1_HIGH   = 8'h8d;
	localparam logic [7:0] DTC_ADDR_CLOCK_CTL = 8'h8e;
	localparam logic [7:0] DTC_ADDR_AUX       = 8'ha2;
	localparam logic [7:0] DTC_ADDR_PORT_MODE = 8'hac;

	// Mode register: unit 0 in the low nibble, unit 1 in the high nibble.
	localparam int DTC_MODE_STRIDE   = 4;
	localparam int DTC_MODE_GATE_BIT = 3;
	localparam int DTC_MODE_CT_BIT   = 2;
	localparam int DTC_MODE_MF_HIGH  = 1;
	localparam int DTC_MODE_MF_LOW   = 0;

	// Control register run and overflow flag positions.
	localparam int DTC_CTL_U0_RUN  = 4;
	localparam int DTC_CTL_U0_FLAG = 5;
	localparam int DTC_CTL_U1_RUN  = 6;
	localparam int DTC_CTL_U1_FLAG = 7;

	// Clock control, auxiliary and port mode bit positions.
	localparam int DTC_CLK_U0_UNDIV = 3;
	localparam int DTC_CLK_U1_UNDIV = 4;
	localparam int DTC_AUX_U0_SLOW  = 4;
	localparam int DTC_AUX_U1_SLOW  = 5;
	localparam int DTC_PORT_U0_TOE  = 6;
	localparam int DTC_PORT_U1_TOE  = 7;

	localparam logic [7:0] DTC_BYTE_RESET  = 8'h00;
	localparam logic [7:0] DTC_BYTE_MAX    = 8'hff;
	localparam logic [4:0] DTC_LOW5_MAX    = 5'h1f;
	localparam logic       DTC_TOGGLE_IDLE = 1'b1;
	localparam int         DTC_PRESCALE    = 12;

	typedef enum logic [1:0] {
		DTC_MODE_13BIT,
		DTC_MODE_16BIT,
		DTC_MODE_RELOAD,
		DTC_MODE_SPLIT
	} dtc_mode_t;

endpackage : dtc_pkg

// [dtc_timer_pair.sv]
// Two 16-bit timer/counter units with their byte registers, mode and
// control registers, prescaler, pin sampling and toggle outputs.
// Assumes a byte register port with one-cycle strobes and pins that are
// asynchronous to i_clock; the interrupt controller acks with a pulse.
`timescale 1ns/1ns
`default_nettype none

module dtc_timer_pair
	import dtc_pkg::*;
#(
	parameter int PRESCALE = DTC_PRESCALE
) (
	input  wire logic       i_clock,
	input  wire logic       i_nrst,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_write,
	input  wire logic       i_read,
	output logic      [7:0] o_rdata,
	input  wire logic       i_unit0_count_pin_in,
	output logic            o_unit0_count_pin_out,
	output logic            o_unit0_count_pin_oe,
	input  wire logic       i_unit1_count_pin_in,
	output logic            o_unit1_count_pin_out,
	output logic            o_unit1_count_pin_oe,
	input  wire logic       i_unit0_gate_pin,
	input  wire logic       i_unit1_gate_pin,
	input  wire logic       i_low_speed_crystal_clock,
	input  wire logic       i_unit0_service_ack,
	input  wire logic       i_unit1_service_ack,
	output logic            o_unit0_irq,
	output logic            o_unit1_irq
);

	// Prescaler width and wrap value; the prescaler runs free from reset,
	// so the first divided tick after a run set may come early.
	localparam int PRE_W = (PRESCALE > 2) ? $clog2(PRESCALE) : 1;
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE - 1);
	localparam logic [PRE_W-1:0] PRE_ZERO = '0;

	// A prescaler of one would merge the divided and undivided paths.
	if (PRESCALE < 2) begin : g_check
		$error("PRESCALE must be at least 2");
	end

	// All state of the pair, registered together on every clock edge.
	typedef struct packed {
		logic [1:0]       run;
		logic [1:0]       flag;
		logic [1:0]       gate;
		logic [1:0]       ctsel;
		logic [1:0][1:0]  mf;
		logic [1:0]       undiv;
		logic [1:0]       slow;
		logic [1:0]       toe;
		logic [1:0]       tog;
		logic [1:0][7:0]  lo;
		logic [1:0][7:0]  hi;
		logic [PRE_W-1:0] pre;
		logic [1:0]       pin_s1;
		logic [1:0]       pin_s2;
		logic [1:0]       pin_s3;
		logic [1:0]       gate_s1;
		logic [1:0]       gate_s2;
		logic             xt_s1;
		logic             xt_s2;
		logic             xt_s3;
		logic [7:0]       rdata;
	} dtc_state_t;

	dtc_state_t s_q;
	dtc_state_t s_d;

	// Per-unit views of the pins and the combinational count decisions.
	logic [1:0]       pin_in;
	logic [1:0]       gate_in;
	logic [1:0]       ack;
	logic             pre_tick;
	logic             xt_rise;
	logic [1:0]       pin_fall;
	logic [1:0]       tick;
	logic [1:0]       en;
	logic [1:0]       ovf;
	logic             high_ovf;
	logic             split0;
	logic [1:0]       flag_set;
	logic [15:0]      full_next;
	logic [4:0]       low5_next;
	logic [7:0]       ctl_rd;
	logic [7:0]       mode_rd;
	logic [7:0]       clk_rd;
	logic [7:0]       aux_rd;
	logic [7:0]       port_rd;
	dtc_mode_t        mode_u;

	// Gather the per-unit pins into vectors indexed by unit.
	assign pin_in  = {i_unit1_count_pin_in, i_unit0_count_pin_in};
	assign gate_in = {i_unit1_gate_pin, i_unit0_gate_pin};
	assign ack     = {i_unit1_service_ack, i_unit0_service_ack};

	always_comb begin
		s_d       = s_q;
		s_d.rdata = DTC_BYTE_RESET;
		full_next = 16'h0000;
		low5_next = 5'h00;
		ovf       = 2'b00;
		high_ovf  = 1'b0;
		flag_set  = 2'b00;
		mode_u    = DTC_MODE_13BIT;

		// Input synchronisers and the edge history stage.
		s_d.pin_s1  = pin_in;
		s_d.pin_s2  = s_q.pin_s1;
		s_d.pin_s3  = s_q.pin_s2;
		s_d.gate_s1 = gate_in;
		s_d.gate_s2 = s_q.gate_s1;
		s_d.xt_s1   = i_low_speed_crystal_clock;
		s_d.xt_s2   = s_q.xt_s1;
		s_d.xt_s3   = s_q.xt_s2;

		pin_fall = s_q.pin_s3 & ~s_q.pin_s2;
		xt_rise  = s_q.xt_s2 & ~s_q.xt_s3;

		// Shared divide-by-PRESCALE prescaler, twelve by default.
		pre_tick = (s_q.pre == PRE_LAST);
		s_d.pre  = pre_tick ? PRE_ZERO : PRE_W'(s_q.pre + 1'b1);

		split0 = (dtc_mode_t'(s_q.mf[0]) == DTC_MODE_SPLIT);

		// Tick source per unit: slow crystal first, then pin, then clock.
		for (int u = 0; u < 2; u++) begin
			if (s_q.slow[u]) begin
				tick[u] = xt_rise;
			end else if (s_q.ctsel[u]) begin
				tick[u] = pin_fall[u];
			end else begin
				tick[u] = s_q.undiv[u] | pre_tick;
			end
			en[u] = (~s_q.gate[u] | s_q.gate_s2[u]);
		end
		// In split mode unit 1 runs regardless of its own run bit.
		en[0] = en[0] & s_q.run[0];
		en[1] = en[1] & (split0 | s_q.run[1]);

		// Count update per unit, one branch per mode field value.
		// A write to a count byte later in this process overrides it.
		for (int u = 0; u < 2; u++) begin
			mode_u = dtc_mode_t'(s_q.mf[u]);
			unique case (mode_u)
				DTC_MODE_13BIT: begin
					if (en[u] && tick[u]) begin
						low5_next = s_q.lo[u][4:0] + 5'h01;
						s_d.lo[u] = {s_q.lo[u][7:5], low5_next};
						if (s_q.lo[u][4:0] == DTC_LOW5_MAX) begin
							s_d.hi[u] = s_q.hi[u] + 8'h01;
							ovf[u] = (s_q.hi[u] == DTC_BYTE_MAX);
						end
					end
				end
				DTC_MODE_16BIT: begin
					if (en[u] && tick[u]) begin
						full_next = {s_q.hi[u], s_q.lo[u]} + 16'h0001;
						s_d.hi[u] = full_next[15:8];
						s_d.lo[u] = full_next[7:0];
						ovf[u] = ({s_q.hi[u], s_q.lo[u]} == 16'hffff);
					end
				end
				DTC_MODE_RELOAD: begin
					if (en[u] && tick[u]) begin
						if (s_q.lo[u] == DTC_BYTE_MAX) begin
							s_d.lo[u] = s_q.hi[u];
							ovf[u] = 1'b1;
						end else begin
							s_d.lo[u] = s_q.lo[u] + 8'h01;
						end
					end
				end
				DTC_MODE_SPLIT: begin
					// Unit 1 holds its count here; unit 0 splits in two.
					if (u == 0) begin
						if (en[0] && tick[0]) begin
							s_d.lo[0] = s_q.lo[0] + 8'h01;
							ovf[0] = (s_q.lo[0] == DTC_BYTE_MAX);
						end
						if (s_q.run[1] && (s_q.undiv[0] || pre_tick)) begin
							s_d.hi[0] = s_q.hi[0] + 8'h01;
							high_ovf = (s_q.hi[0] == DTC_BYTE_MAX);
						end
					end
				end
			endcase
		end

		// Split mode hands the high byte's wrap to unit 1's flag.
		flag_set[0] = ovf[0];
		flag_set[1] = split0 ? high_ovf : ovf[1];

		// Toggle outputs idle high while disabled and flip on overflow.
		for (int u = 0; u < 2; u++) begin
			if (!s_q.toe[u]) begin
				s_d.tog[u] = DTC_TOGGLE_IDLE;
			end else if (ovf[u]) begin
				s_d.tog[u] = ~s_q.tog[u];
			end
			if (ack[u]) begin
				s_d.flag[u] = 1'b0;
			end
		end

		// Register writes; byte writes beat a same-cycle increment.
		if (i_write) begin
			unique case (i_addr)
				DTC_ADDR_CONTROL: begin
					s_d.run[0]  = i_wdata[DTC_CTL_U0_RUN];
					s_d.run[1]  = i_wdata[DTC_CTL_U1_RUN];
					s_d.flag[0] = i_wdata[DTC_CTL_U0_FLAG];
					s_d.flag[1] = i_wdata[DTC_CTL_U1_FLAG];
				end
				DTC_ADDR_MODE: begin
					for (int u = 0; u < 2; u++) begin
						s_d.gate[u]  = i_wdata[DTC_MODE_STRIDE*u
							+ DTC_MODE_GATE_BIT];
						s_d.ctsel[u] = i_wdata[DTC_MODE_STRIDE*u
							+ DTC_MODE_CT_BIT];
						s_d.mf[u] = {i_wdata[DTC_MODE_STRIDE*u
							+ DTC_MODE_MF_HIGH], i_wdata[DTC_MODE_STRIDE*u
							+ DTC_MODE_MF_LOW]};
					end
				end
				DTC_ADDR_U0_LOW:  s_d.lo[0] = i_wdata;
				DTC_ADDR_U1_LOW:  s_d.lo[1] = i_wdata;
				DTC_ADDR_U0_HIGH: s_d.hi[0] = i_wdata;
				DTC_ADDR_U1_HIGH: s_d.hi[1] = i_wdata;
				DTC_ADDR_CLOCK_CTL: begin
					s_d.undiv[0] = i_wdata[DTC_CLK_U0_UNDIV];
					s_d.undiv[1] = i_wdata[DTC_CLK_U1_UNDIV];
				end
				DTC_ADDR_AUX: begin
					s_d.slow[0] = i_wdata[DTC_AUX_U0_SLOW];
					s_d.slow[1] = i_wdata[DTC_AUX_U1_SLOW];
				end
				DTC_ADDR_PORT_MODE: begin
					s_d.toe[0] = i_wdata[DTC_PORT_U0_TOE];
					s_d.toe[1] = i_wdata[DTC_PORT_U1_TOE];
				end
				default: begin
				end
			endcase
		end

		// Hardware set wins over a software or acknowledge clear.
		s_d.flag = s_d.flag | flag_set;

		// Readback images; bits that hold no control read as zero.
		ctl_rd = DTC_BYTE_RESET;
		ctl_rd[DTC_CTL_U0_RUN]  = s_q.run[0];
		ctl_rd[DTC_CTL_U1_RUN]  = s_q.run[1];
		ctl_rd[DTC_CTL_U0_FLAG] = s_q.flag[0];
		ctl_rd[DTC_CTL_U1_FLAG] = s_q.flag[1];
		mode_rd = DTC_BYTE_RESET;
		for (int u = 0; u < 2; u++) begin
			mode_rd[DTC_MODE_STRIDE*u + DTC_MODE_GATE_BIT] = s_q.gate[u];
			mode_rd[DTC_MODE_STRIDE*u + DTC_MODE_CT_BIT]   = s_q.ctsel[u];
			mode_rd[DTC_MODE_STRIDE*u + DTC_MODE_MF_HIGH]  = s_q.mf[u][1];
			mode_rd[DTC_MODE_STRIDE*u + DTC_MODE_MF_LOW]   = s_q.mf[u][0];
		end
		clk_rd = DTC_BYTE_RESET;
		clk_rd[DTC_CLK_U0_UNDIV] = s_q.undiv[0];
		clk_rd[DTC_CLK_U1_UNDIV] = s_q.undiv[1];
		aux_rd = DTC_BYTE_RESET;
		aux_rd[DTC_AUX_U0_SLOW] = s_q.slow[0];
		aux_rd[DTC_AUX_U1_SLOW] = s_q.slow[1];
		port_rd = DTC_BYTE_RESET;
		port_rd[DTC_PORT_U0_TOE] = s_q.toe[0];
		port_rd[DTC_PORT_U1_TOE] = s_q.toe[1];

		// Read data stands only in the cycle after the read strobe.
		if (i_read) begin
			unique case (i_addr)
				DTC_ADDR_CONTROL:   s_d.rdata = ctl_rd;
				DTC_ADDR_MODE:      s_d.rdata = mode_rd;
				DTC_ADDR_U0_LOW:    s_d.rdata = s_q.lo[0];
				DTC_ADDR_U1_LOW:    s_d.rdata = s_q.lo[1];
				DTC_ADDR_U0_HIGH:   s_d.rdata = s_q.hi[0];
				DTC_ADDR_U1_HIGH:   s_d.rdata = s_q.hi[1];
				DTC_ADDR_CLOCK_CTL: s_d.rdata = clk_rd;
				DTC_ADDR_AUX:       s_d.rdata = aux_rd;
				DTC_ADDR_PORT_MODE: s_d.rdata = port_rd;
				default:            s_d.rdata = DTC_BYTE_RESET;
			endcase
		end
	end

	// Pin synchronisers reset to the idle levels of their pins, so that
	// no false falling edge is counted just after reset.
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			s_q         <= '0;
			s_q.lo      <= {DTC_BYTE_RESET, DTC_BYTE_RESET};
			s_q.hi      <= {DTC_BYTE_RESET, DTC_BYTE_RESET};
			s_q.tog     <= {DTC_TOGGLE_IDLE, DTC_TOGGLE_IDLE};
			s_q.pin_s1  <= 2'b11;
			s_q.pin_s2  <= 2'b11;
			s_q.pin_s3  <= 2'b11;
			s_q.gate_s1 <= 2'b00;
			s_q.gate_s2 <= 2'b00;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from the registered state.
	assign o_rdata               = s_q.rdata;
	assign o_unit0_count_pin_out = s_q.tog[0];
	assign o_unit0_count_pin_oe  = s_q.toe[0];
	assign o_unit1_count_pin_out = s_q.tog[1];
	assign o_unit1_count_pin_oe  = s_q.toe[1];
	assign o_unit0_irq           = s_q.flag[0];
	assign o_unit1_irq           = s_q.flag[1];

endmodule : dtc_timer_pair

`default_nettype wire

// [dtc_pins_model.sv]
// Pin-side model: count pin bursts, slow crystal pulses, pin resolving.
// Assumes the bench clock and reset; starts a burst on a start pulse.
`timescale 1ns/1ns
`default_nettype none
module dtc_pins_model (
	input  wire logic       i_clock,
	input  wire logic       i_nrst,
	input  wire logic       i_start,
	input  wire logic [2:0] i_count,
	input  wire logic       i_oe0,
	input  wire logic       i_out0,
	input  wire logic       i_oe1,
	input  wire logic       i_out1,
	output logic            o_pin0,
	output logic            o_pin1,
	output logic            o_xtal,
	output logic            o_busy
);
	logic [2:0] left_q;
	logic [2:0] ph_q;
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			left_q <= 3'h0;
			ph_q   <= 3'h0;
		end else if (i_start) begin
			left_q <= i_count;
			ph_q   <= 3'h0;
		end else if (o_busy) begin
			ph_q <= ph_q + 3'h1;
			if (ph_q == 3'h7) begin
				left_q <= left_q - 3'h1;
			end
		end
	end
	assign o_busy = left_q != 3'h0;
	// Each period is four clocks high, four low; two crystal rises.
	assign o_pin0 = i_oe0 ? i_out0 : (!o_busy || !ph_q[2]);
	assign o_pin1 = i_oe1 ? i_out1 : 1'b1;
	assign o_xtal = o_busy && ph_q[1];
endmodule : dtc_pins_model
`default_nettype wire

// [dtc_timer_pair_sva.sv]
// Checker for the timer pair register port, flags and toggle enables.
// Assumes it is bound to the top module by the bind at the foot.
`timescale 1ns/1ns
`default_nettype none
module dtc_timer_pair_sva
	import dtc_pkg::*;
#(
	parameter int PRESCALE = DTC_PRESCALE
) (
	input wire logic       i_clock,
	input wire logic       i_nrst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_write,
	input wire logic       i_read,
	input wire logic [7:0] o_rdata,
	input wire logic       o_unit0_count_pin_out,
	input wire logic       o_unit0_count_pin_oe,
	input wire logic       o_unit1_count_pin_oe,
	input wire logic       i_unit0_service_ack,
	input wire logic       o_unit0_irq,
	input wire logic       o_unit1_irq
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	sequence s_mode_wr;
		i_write && i_addr == DTC_ADDR_MODE;
	endsequence
	sequence s_mode_rd;
		i_read && i_addr == DTC_ADDR_MODE;
	endsequence
	property p_mode_rb;
		s_mode_wr ##1 s_mode_rd |=> o_rdata == $past(i_wdata, 2);
	endproperty
	a_mode_rb: assert property (p_mode_rb)
		else $error("mode readback wrong");
	property p_rd_idle;
		!$past(i_read) |-> o_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read slot");
	property p_ctl_rd;
		i_read && i_addr == DTC_ADDR_CONTROL |=> o_rdata[3:0] == 4'h0
			&& o_rdata[7] == $past(o_unit1_irq)
			&& o_rdata[5] == $past(o_unit0_irq);
	endproperty
	a_ctl_rd: assert property (p_ctl_rd)
		else $error("control read differs from flags");
	property p_flag_wr;
		i_write && i_addr == DTC_ADDR_CONTROL && i_wdata[5] |=> o_unit0_irq;
	endproperty
	a_flag_wr: assert property (p_flag_wr)
		else $error("software flag set lost");
	property p_tog_rise;
		$rose(o_unit0_count_pin_oe) |-> o_unit0_count_pin_out;
	endproperty
	a_tog_rise: assert property (p_tog_rise)
		else $error("toggle pin not high on enable");
	property p_oe_wr;
		i_write && i_addr == DTC_ADDR_PORT_MODE
			|=> o_unit0_count_pin_oe == $past(i_wdata[6]);
	endproperty
	a_oe_wr: assert property (p_oe_wr)
		else $error("toggle enable not applied");
	property p_oe1_rise;
		$rose(o_unit1_count_pin_oe)
			|-> $past(i_write) && $past(i_addr) == DTC_ADDR_PORT_MODE;
	endproperty
	a_oe1_rise: assert property (p_oe1_rise)
		else $error("toggle enable rose without write");
	property p_irq0_fall;
		$fell(o_unit0_irq) |-> $past(i_unit0_service_ack)
			|| ($past(i_write) && $past(i_addr) == DTC_ADDR_CONTROL);
	endproperty
	a_irq0_fall: assert property (p_irq0_fall)
		else $error("flag cleared without cause");
endmodule : dtc_timer_pair_sva
bind dtc_timer_pair dtc_timer_pair_sva #(.PRESCALE(PRESCALE)) u_sva (.*);
`default_nettype wire

// [dtc_timer_pair_tb_top.sv]
// Self-checking bench: reset values, registers, modes, pins, flags.
// Assumes the pin model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
module dtc_timer_pair_tb_top
	import dtc_pkg::*;
();
	logic        i_clock, i_nrst, i_write, i_read, start, busy;
	logic [7:0]  i_addr, i_wdata, o_rdata, d, v, hi;
	logic        o_unit0_count_pin_out, o_unit0_count_pin_oe;
	logic        o_unit1_count_pin_out, o_unit1_count_pin_oe;
	logic        i_unit0_count_pin_in, i_unit1_count_pin_in;
	logic        i_unit0_gate_pin, i_unit1_gate_pin;
	logic        i_low_speed_crystal_clock, tog;
	logic        i_unit0_service_ack, i_unit1_service_ack;
	logic        o_unit0_irq, o_unit1_irq;
	logic [2:0]  cnt, k;
	logic [31:0] seed = 32'hea90;
	logic [7:0]  ra [5] = '{DTC_ADDR_U0_LOW, DTC_ADDR_U0_HIGH,
		DTC_ADDR_U1_LOW, DTC_ADDR_CONTROL, 8'h00};
	int          n_mismatch = 0;
	int          cmp_count = 0;
	int          n;
	initial begin
		i_clock = 1'b0;
		forever #20 i_clock = ~i_clock;
	end
	dtc_timer_pair #(.PRESCALE(4)) uut (.*);
	dtc_pins_model u_pins (.i_clock(i_clock), .i_nrst(i_nrst),
		.i_start(start), .i_count(cnt), .i_oe0(o_unit0_count_pin_oe),
		.i_out0(o_unit0_count_pin_out), .i_oe1(o_unit1_count_pin_oe),
		.i_out1(o_unit1_count_pin_out), .o_pin0(i_unit0_count_pin_in),
		.o_pin1(i_unit1_count_pin_in), .o_xtal(i_low_speed_crystal_clock),
		.o_busy(busy));
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : rnd
	function automatic logic [7:0] exp_ev(input logic s, g, l,
		input logic [2:0] c);
		if (g && !l) return 8'h00;
		return s ? {4'h0, c, 1'b0} : {5'h0, c};
	endfunction : exp_ev
	task automatic test_done();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : test_done
	task automatic chk8(input string nm, input logic [7:0] e, g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk8
	task automatic wr(input logic [7:0] a, w);
		#1;
		i_write <= 1'b1;
		i_addr  <= a;
		i_wdata <= w;
		@(posedge i_clock);
		i_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		#1;
		i_read <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_read <= 1'b0;
		#1 d = o_rdata;
	endtask : rd
	task automatic wait_for(ref logic s, input logic lvl);
		n = 0;
		while (s !== lvl && n < 200) begin
			@(posedge i_clock);
			#1 n++;
		end
		if (n == 200) begin
			n_mismatch++;
			test_done();
		end
	endtask : wait_for
	initial begin
		i_nrst = 1'b0;
		{i_write, i_read, start, tog, i_unit0_service_ack} = '0;
		{i_addr, i_wdata, cnt, i_unit0_gate_pin} = '0;
		{i_unit1_gate_pin, i_unit1_service_ack} = '0;
		repeat (20) @(posedge i_clock);
		i_nrst <= 1'b1;
		@(posedge i_clock);
		foreach (ra[i]) begin
			rd(ra[i]);
			chk8("reset", 8'h00, d);
		end
		wr(DTC_ADDR_CONTROL, 8'ha0);
		rd(DTC_ADDR_CONTROL);
		chk8("control", 8'ha0, d);
		wr(DTC_ADDR_CONTROL, 8'h00);
		repeat (4) begin
			v = rnd() & 8'hfc;
			wr(DTC_ADDR_MODE, v);
			rd(DTC_ADDR_MODE);
			chk8("mode", v, d);
			v = rnd();
			wr(DTC_ADDR_U0_LOW, v);
			wr(DTC_ADDR_U0_HIGH, ~v);
			rd(DTC_ADDR_U0_LOW);
			chk8("low", v, d);
			rd(DTC_ADDR_U0_HIGH);
			chk8("high", ~v, d);
		end
		wr(DTC_ADDR_PORT_MODE, 8'hc0);
		tog = 1'b1;
		for (int i = 0; i < 8; i++) begin
			hi = (i[1:0] < 2'h2) ? 8'hff : (rnd() & 8'h7f);
			wr(DTC_ADDR_MODE, {6'h0, i[1:0]});
			wr(DTC_ADDR_CLOCK_CTL, {4'h0, i[2], 3'h0});
			wr(DTC_ADDR_U0_HIGH, hi);
			wr(DTC_ADDR_U0_LOW, 8'hfe);
			wr(DTC_ADDR_CONTROL, 8'h10);
			wait_for(o_unit0_irq, 1'b1);
			wr(DTC_ADDR_CONTROL, 8'h20);
			chk8("pace", 8'h01, {7'h0, i[2] ? n <= 3 : n >= 4});
			rd(DTC_ADDR_U0_HIGH);
			v = (i[1:0] < 2'h2) ? hi + 8'h01 : hi;
			chk8("high", v, d);
			rd(DTC_ADDR_U0_LOW);
			if (i[1:0] == 2'h0) chk8("low", 8'h07, {5'h0, d[7:5]});
			tog = ~tog;
			chk8("toggle", {7'h0, tog}, {7'h0, o_unit0_count_pin_out});
			i_unit0_service_ack <= 1'b1;
			@(posedge i_clock);
			i_unit0_service_ack <= 1'b0;
			#1 chk8("irq", 8'h00, {7'h0, o_unit0_irq});
		end
		wr(DTC_ADDR_PORT_MODE, 8'h00);
		for (int j = 0; j < 4; j++) begin
			k = 3'(rnd() % 8'd5 + 8'd1);
			i_unit0_gate_pin <= rnd() > 8'h7f;
			wr(DTC_ADDR_AUX, {3'h0, j[0], 4'h0});
			wr(DTC_ADDR_MODE, {4'h0, j[1], 3'h5});
			wr(DTC_ADDR_U0_LOW, 8'h00);
			wr(DTC_ADDR_CONTROL, 8'h10);
			cnt <= k;
			start <= 1'b1;
			@(posedge i_clock);
			start <= 1'b0;
			#1 wait_for(busy, 1'b0);
			repeat (6) @(posedge i_clock);
			wr(DTC_ADDR_CONTROL, 8'h00);
			rd(DTC_ADDR_U0_LOW);
			v = exp_ev(j[0], j[1], i_unit0_gate_pin, k);
			chk8("events", v, d);
		end
		wr(DTC_ADDR_MODE, 8'h03);
		wr(DTC_ADDR_CLOCK_CTL, 8'h08);
		wr(DTC_ADDR_U0_HIGH, 8'hfe);
		wr(DTC_ADDR_CONTROL, 8'h40);
		wait_for(o_unit1_irq, 1'b1);
		chk8("split pace", 8'h01, {7'h0, n <= 3});
		wr(DTC_ADDR_CONTROL, 8'h80);
		rd(DTC_ADDR_U0_HIGH);
		chk8("split high", 8'h01, d);
		i_unit1_service_ack <= 1'b1;
		@(posedge i_clock);
		i_unit1_service_ack <= 1'b0;
		#1 chk8("unit1 pins", 8'h00, {5'h0, ~o_unit1_count_pin_out,
			o_unit1_count_pin_oe, o_unit1_irq});
		test_done();
	end
endmodule : dtc_timer_pair_tb_top
`default_nettype wire
